// ---- hdl/aerr_regs.sv ----
/*
 Error reporting register bank of one switch port: correctable status and
 mask, the upper uncorrectable severity bits with their status and mask,
 error control and the first two header log words, on an APB slave.
 Assumes event inputs are one-cycle pulses from logic on mclk, reset_n is
 the power-on reset and warmReset a synchronous non-power-on reset.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module aerr_regs
	import aerr_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire logic                   clkEn,
	input  wire logic                   warmReset,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [AERR_ADDR_W-1:0] paddr,
	input  wire logic [AERR_DATA_W-1:0] pwdata,
	output logic      [AERR_DATA_W-1:0] prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire aerr_corr_evt_t         corrEvt,
	input  wire aerr_unc_evt_t          uncEvt,
	output aerr_report_t                report,
	output logic                        crcGenOn,
	output logic                        crcCheckOn
);

	// Bus decode
	logic                   setupPhase;
	logic                   wrStrobe;
	logic                   addrHit;
	logic [AERR_DATA_W-1:0] nxt_prdata;
	logic [AERR_DATA_W-1:0] prdata_ff;
	logic                   pslverr_ff;

	// Register state
	logic [AERR_CE_NUM-1:0] ceMask_ff;
	logic [AERR_CE_NUM-1:0] ceStatus;
	logic [AERR_CE_NUM-1:0] ceClr;
	logic [AERR_CE_NUM-1:0] ceSet;
	logic [31:0]            ceStatusWord;
	logic [31:0]            ceMaskWord;
	logic [AERR_UE_NUM-1:0] ueMask_ff;
	logic [AERR_UE_NUM-1:0] ueSev_ff;
	logic [AERR_UE_NUM-1:0] ueStatus;
	logic [AERR_UE_NUM-1:0] ueClr;
	logic [AERR_UE_NUM-1:0] ueSet;
	logic [AERR_UE_NUM-1:0] ueRaw;
	logic [4:0]             firstPtr_ff;
	logic [4:0]             nxt_firstPtr;
	logic                   genCap_ff;
	logic                   genEn_ff;
	logic                   chkCap_ff;
	logic                   chkEn_ff;
	logic                   capLock_ff;
	logic [31:0]            hdrFirst_ff;
	logic [31:0]            hdrSecond_ff;
	logic                   logFrozen;
	logic                   logCapture;
	aerr_report_t           report_ff;
	aerr_report_t           nxt_report;

	// Zero-wait slave; a frozen clock holds the access phase open
	assign setupPhase = psel && !penable;
	assign wrStrobe   = psel && penable && pwrite && clkEn;
	assign pready     = clkEn;
	assign prdata     = prdata_ff;
	assign pslverr    = pslverr_ff;

	// Address hit check, unaligned offsets count as unmapped
	always_comb begin
		unique case (paddr)
			AERR_OFF_UNC_STATUS,
			AERR_OFF_UNC_MASK,
			AERR_OFF_UNC_SEV,
			AERR_OFF_CORR_STAT,
			AERR_OFF_CORR_MASK,
			AERR_OFF_ERR_CTL,
			AERR_OFF_HDR_FIRST,
			AERR_OFF_HDR_SECOND,
			AERR_OFF_CAP_LOCK: addrHit = 1'b1;
			default: addrHit = 1'b0;
		endcase
	end

	// Gather the correctable clear bits from their word positions into packed order
	generate
		for (genvar i = 0; i < AERR_CE_NUM; i++) begin : g_ceMap
			assign ceSet[i] = corrEvt[i];
			assign ceClr[i] = wrStrobe && (paddr == AERR_OFF_CORR_STAT)
				&& pwdata[AERR_CE_POS[i]];
		end
	endgenerate

	// Reserved status and mask positions stay zero
	always_comb begin
		ceStatusWord = '0;
		ceMaskWord   = '0;
		for (int i = 0; i < AERR_CE_NUM; i++) begin
			ceStatusWord[AERR_CE_POS[i]] = ceStatus[i];
			ceMaskWord[AERR_CE_POS[i]]   = ceMask_ff[i];
		end
	end

	// Correctable status flags, sticky and write-one-to-clear
	aerr_sticky_bits #(
		.W (AERR_CE_NUM)
	) u_ceStatus (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.setVec  (ceSet),
		.clrVec  (ceClr),
		.status  (ceStatus)
	);

	// Masked uncorrectable events are neither logged nor reported
	assign ueRaw = {uncEvt.unsupReq, uncEvt.crcErr};
	assign ueSet = ueRaw & ~ueMask_ff;
	assign ueClr = {2{wrStrobe && (paddr == AERR_OFF_UNC_STATUS)}}
		& {pwdata[AERR_UE_UNSUP_POS], pwdata[AERR_UE_ECRC_POS]};

	// Uncorrectable status for the two kept events
	aerr_sticky_bits #(
		.W (AERR_UE_NUM)
	) u_ueStatus (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clkEn   (clkEn),
		.setVec  (ueSet),
		.clrVec  (ueClr),
		.status  (ueStatus)
	);

	// Log stays frozen while the bit it points at is still set
	always_comb begin
		logFrozen = 1'b0;
		if (firstPtr_ff == AERR_UE_ECRC_POS) begin
			logFrozen = ueStatus[0] && !ueClr[0];
		end else if (firstPtr_ff == AERR_UE_UNSUP_POS) begin
			logFrozen = ueStatus[1] && !ueClr[1];
		end
	end

	// ECRC wins when both arrive together
	assign logCapture   = (|ueSet) && !logFrozen;
	assign nxt_firstPtr = ueSet[0] ? AERR_UE_ECRC_POS : AERR_UE_UNSUP_POS;

	// First error pointer, sticky
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			firstPtr_ff <= AERR_PTR_RST;
		end else if (clkEn && logCapture) begin
			firstPtr_ff <= nxt_firstPtr;
		end
	end

	// Second header word, sticky
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hdrSecond_ff <= AERR_HDR_RST;
		end else if (clkEn && logCapture) begin
			hdrSecond_ff <= uncEvt.hdrSecond;
		end
	end

	// First header word is not sticky, so warm reset clears it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hdrFirst_ff <= AERR_HDR_RST;
		end else if (clkEn) begin
			if (warmReset) begin
				hdrFirst_ff <= AERR_HDR_RST;
			end else if (logCapture) begin
				hdrFirst_ff <= uncEvt.hdrFirst;
			end
		end
	end

	// Uncorrectable mask and severity, sticky
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ueMask_ff <= AERR_UE_MASK_RST;
			ueSev_ff  <= AERR_UE_SEV_RST;
		end else if (clkEn && wrStrobe) begin
			if (paddr == AERR_OFF_UNC_MASK) begin
				ueMask_ff <= {pwdata[AERR_UE_UNSUP_POS], pwdata[AERR_UE_ECRC_POS]};
			end
			if (paddr == AERR_OFF_UNC_SEV) begin
				ueSev_ff <= {pwdata[AERR_UE_UNSUP_POS], pwdata[AERR_UE_ECRC_POS]};
			end
		end
	end

	// Correctable mask, sticky; advisory masked out of reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ceMask_ff <= AERR_CE_MASK_RST;
		end else if (clkEn && wrStrobe && (paddr == AERR_OFF_CORR_MASK)) begin
			for (int i = 0; i < AERR_CE_NUM; i++) begin
				ceMask_ff[i] <= pwdata[AERR_CE_POS[i]];
			end
		end
	end

	// CRC enables, sticky
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			genEn_ff <= AERR_EN_RST;
			chkEn_ff <= AERR_EN_RST;
		end else if (clkEn && wrStrobe && (paddr == AERR_OFF_ERR_CTL)) begin
			genEn_ff <= pwdata[AERR_CTL_GEN_EN];
			chkEn_ff <= pwdata[AERR_CTL_CHK_EN];
		end
	end

	// Capability bits and their lock; warm reset restores both
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			genCap_ff  <= AERR_CAP_RST;
			chkCap_ff  <= AERR_CAP_RST;
			capLock_ff <= AERR_LOCK_RST;
		end else if (clkEn) begin
			if (warmReset) begin
				genCap_ff  <= AERR_CAP_RST;
				chkCap_ff  <= AERR_CAP_RST;
				capLock_ff <= AERR_LOCK_RST;
			end else if (wrStrobe) begin
				if (paddr == AERR_OFF_CAP_LOCK) begin
					capLock_ff <= pwdata[0];
				end
				if ((paddr == AERR_OFF_ERR_CTL) && !capLock_ff) begin
					genCap_ff <= pwdata[AERR_CTL_GEN_CAP];
					chkCap_ff <= pwdata[AERR_CTL_CHK_CAP];
				end
			end
		end
	end

	// Enables only count when the matching capability is present
	assign crcGenOn   = genEn_ff && genCap_ff;
	assign crcCheckOn = chkEn_ff && chkCap_ff;

	// Messages toward the root complex
	always_comb begin
		nxt_report             = '0;
		nxt_report.correctable = |(ceSet & ~ceMask_ff);
		nxt_report.fatal       = |(ueSet & ueSev_ff);
		nxt_report.nonFatal    = |(ueSet & ~ueSev_ff);
	end

	// Registered so each message is a clean one-cycle pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			report_ff <= '0;
		end else if (clkEn) begin
			report_ff <= nxt_report;
		end
	end

	assign report = report_ff;

	// Read mux; reserved bits and unmapped offsets return zero
	always_comb begin
		nxt_prdata = '0;
		unique case (paddr)
			AERR_OFF_UNC_STATUS: begin
				nxt_prdata[AERR_UE_ECRC_POS]  = ueStatus[0];
				nxt_prdata[AERR_UE_UNSUP_POS] = ueStatus[1];
			end
			AERR_OFF_UNC_MASK: begin
				nxt_prdata[AERR_UE_ECRC_POS]  = ueMask_ff[0];
				nxt_prdata[AERR_UE_UNSUP_POS] = ueMask_ff[1];
			end
			AERR_OFF_UNC_SEV: begin
				nxt_prdata[AERR_UE_ECRC_POS]  = ueSev_ff[0];
				nxt_prdata[AERR_UE_UNSUP_POS] = ueSev_ff[1];
			end
			AERR_OFF_CORR_STAT: begin
				nxt_prdata = ceStatusWord;
			end
			AERR_OFF_CORR_MASK: begin
				nxt_prdata = ceMaskWord;
			end
			AERR_OFF_ERR_CTL: begin
				nxt_prdata[AERR_CTL_PTR_MSB:0] = firstPtr_ff;
				nxt_prdata[AERR_CTL_GEN_CAP]   = genCap_ff;
				nxt_prdata[AERR_CTL_GEN_EN]    = genEn_ff;
				nxt_prdata[AERR_CTL_CHK_CAP]   = chkCap_ff;
				nxt_prdata[AERR_CTL_CHK_EN]    = chkEn_ff;
			end
			AERR_OFF_HDR_FIRST: begin
				nxt_prdata = hdrFirst_ff;
			end
			AERR_OFF_HDR_SECOND: begin
				nxt_prdata = hdrSecond_ff;
			end
			AERR_OFF_CAP_LOCK: begin
				nxt_prdata[0] = capLock_ff;
			end
			default: begin
				nxt_prdata = '0;
			end
		endcase
	end

	// Read data and error sampled in setup, held through access
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (clkEn && setupPhase) begin
			prdata_ff  <= pwrite ? '0 : nxt_prdata;
			pslverr_ff <= !addrHit;
		end
	end

endmodule
`default_nettype wire

// ---- include/aerr_pkg.sv ----
/*
 Constants, field layouts and carrier types for the per-port error
 reporting register bank. Assumes an APB master with 32-bit data and a
 single core clock shared with the layers that raise the error events.
*/
package aerr_pkg;

	localparam int unsigned AERR_ADDR_W = 12;
	localparam int unsigned AERR_DATA_W = 32;

	// Register byte offsets
	localparam logic [11:0] AERR_OFF_UNC_STATUS = 12'h104;
	localparam logic [11:0] AERR_OFF_UNC_MASK   = 12'h108;
	localparam logic [11:0] AERR_OFF_UNC_SEV    = 12'h10c;
	localparam logic [11:0] AERR_OFF_CORR_STAT  = 12'h110;
	localparam logic [11:0] AERR_OFF_CORR_MASK  = 12'h114;
	localparam logic [11:0] AERR_OFF_ERR_CTL    = 12'h118;
	localparam logic [11:0] AERR_OFF_HDR_FIRST  = 12'h11c;
	localparam logic [11:0] AERR_OFF_HDR_SECOND = 12'h120;
	localparam logic [11:0] AERR_OFF_CAP_LOCK   = 12'h130;

	// Uncorrectable bit positions (status, mask and severity share them)
	localparam logic [4:0] AERR_UE_ECRC_POS  = 5'h13;
	localparam logic [4:0] AERR_UE_UNSUP_POS = 5'h14;
	localparam int unsigned AERR_UE_NUM = 2;
	localparam logic [AERR_UE_NUM-1:0] AERR_UE_MASK_RST = 2'h0;
	localparam logic [AERR_UE_NUM-1:0] AERR_UE_SEV_RST  = 2'h0;

	// Correctable bit positions, index order matches aerr_corr_evt_t
	localparam int unsigned AERR_CE_NUM = 6;
	localparam logic [4:0] AERR_CE_POS [AERR_CE_NUM] = '{
		5'h00, 5'h06, 5'h07, 5'h08, 5'h0c, 5'h0d};
	localparam logic [AERR_CE_NUM-1:0] AERR_CE_MASK_RST = 6'h20;

	// Error control field layout
	localparam int unsigned AERR_CTL_PTR_MSB = 4;
	localparam int unsigned AERR_CTL_GEN_CAP = 5;
	localparam int unsigned AERR_CTL_GEN_EN  = 6;
	localparam int unsigned AERR_CTL_CHK_CAP = 7;
	localparam int unsigned AERR_CTL_CHK_EN  = 8;
	localparam logic [4:0] AERR_PTR_RST     = 5'h00;
	localparam logic       AERR_CAP_RST     = 1'h1;
	localparam logic       AERR_EN_RST      = 1'h0;
	localparam logic       AERR_LOCK_RST    = 1'h1;
	localparam logic [31:0] AERR_HDR_RST    = 32'h0000_0000;

	// Correctable events, bit 0 is receiver error
	typedef struct packed {
		logic advisory_nonfatal_flag;
		logic replay_timeout_flag;
		logic replay_rollover_flag;
		logic bad_link_packet_flag;
		logic bad_packet_flag;
		logic receiver_error_flag;
	} aerr_corr_evt_t;

	// Uncorrectable events with the header of the offending packet
	typedef struct packed {
		logic        unsupReq;
		logic        crcErr;
		logic [31:0] hdrFirst;
		logic [31:0] hdrSecond;
	} aerr_unc_evt_t;

	// Messages toward the root complex, one-cycle pulses
	typedef struct packed {
		logic fatal;
		logic nonFatal;
		logic correctable;
	} aerr_report_t;

endpackage

// ---- hdl/aerr_sticky_bits.sv ----
/*
 A vector of hardware-set, write-one-to-clear status flags.
 Assumes set and clear come from logic on mclk; only the power-on reset
 clears it, so the flags survive warm resets.
*/
`timescale 1ns/1ps
`default_nettype none
module aerr_sticky_bits
	import aerr_pkg::*;
#(
	parameter int unsigned W = 6
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] setVec,
	input  wire logic [W-1:0] clrVec,
	output logic      [W-1:0] status
);

	logic [W-1:0] flag_ff;
	logic [W-1:0] nxt_flag;

	// Set beats clear so an event in the clearing cycle is kept
	always_comb begin
		nxt_flag = (flag_ff & ~clrVec) | setVec;
	end

	// Power-on reset only; warm reset never reaches these
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flag_ff <= '0;
		end else if (clkEn) begin
			flag_ff <= nxt_flag;
		end
	end

	assign status = flag_ff;

endmodule
`default_nettype wire

// ---- verif/aerr_root_model.sv ----
/*
 Root complex stand-in that counts error messages from the port.
 Assumes report pulses last one mclk cycle per event.
*/
`timescale 1ns/1ps
`default_nettype none
module aerr_root_model
	import aerr_pkg::*;
(
	input  wire logic   mclk,
	input  wire logic   reset_n,
	input  wire aerr_report_t report,
	output var int      fatalCnt,
	output var int      nonFatalCnt,
	output var int      corrCnt
);
	// One count per pulse cycle, so stuck pulses show as extra counts
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fatalCnt <= 0;
			nonFatalCnt <= 0;
			corrCnt <= 0;
		end else begin
			fatalCnt <= fatalCnt + int'(report.fatal);
			nonFatalCnt <= nonFatalCnt + int'(report.nonFatal);
			corrCnt <= corrCnt + int'(report.correctable);
		end
	end
endmodule
`default_nettype wire

// ---- verif/aerr_regs_asserts.sv ----
/*
 Port checker for aerr_regs, bound to every instance.
 Assumes one mclk domain with reset_n as the only disable.
*/
`timescale 1ns/1ps
`default_nettype none
module aerr_regs_asserts
	import aerr_pkg::*;
(
	input wire logic                   mclk,
	input wire logic                   reset_n,
	input wire logic                   clkEn,
	input wire logic                   warmReset,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [AERR_ADDR_W-1:0] paddr,
	input wire logic [AERR_DATA_W-1:0] prdata,
	input wire logic                   pslverr,
	input wire aerr_corr_evt_t         corrEvt,
	input wire aerr_unc_evt_t          uncEvt,
	input wire aerr_report_t           report,
	input wire logic                   crcGenOn,
	input wire logic                   crcCheckOn
);
	// Only writes to the control word or a warm reset may move the CRC enables
	logic ctlWr;
	assign ctlWr = psel && penable && pwrite && clkEn && paddr == AERR_OFF_ERR_CTL;

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence apbSetup;
		psel && !penable && clkEn;
	endsequence
	sequence oneUnc;
		clkEn && (uncEvt.crcErr ^ uncEvt.unsupReq);
	endsequence

	a_corr_cause: assert property (clkEn && corrEvt == '0 |=> !report.correctable)
		else $error("correctable report without event");
	a_fatal_cause: assert property ($past(clkEn) && report.fatal
		|-> $past(uncEvt.crcErr) || $past(uncEvt.unsupReq))
		else $error("fatal report without event");
	a_nonfatal_cause: assert property ($past(clkEn) && report.nonFatal
		|-> $past(uncEvt.crcErr) || $past(uncEvt.unsupReq))
		else $error("non-fatal report without event");
	a_single_severity: assert property (oneUnc |=> !(report.fatal && report.nonFatal))
		else $error("one event reported at two severities");
	a_gen_cause: assert property ($changed(crcGenOn) |-> $past(ctlWr) || $past(warmReset))
		else $error("generate enable moved without cause");
	a_check_cause: assert property ($changed(crcCheckOn) |-> $past(ctlWr) || $past(warmReset))
		else $error("check enable moved without cause");
	a_warm_keeps: assert property (clkEn && warmReset && !ctlWr
		|=> !$past(crcGenOn) || crcGenOn)
		else $error("warm reset dropped generate enable");
	a_bad_addr: assert property (apbSetup ##0 (paddr[1:0] != 2'h0)
		|=> pslverr && prdata == '0)
		else $error("unaligned access not refused");
endmodule

bind aerr_regs aerr_regs_asserts chk (
	.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .warmReset(warmReset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .corrEvt(corrEvt), .uncEvt(uncEvt),
	.report(report), .crcGenOn(crcGenOn), .crcCheckOn(crcCheckOn)
);
`default_nettype wire

// ---- verif/aerr_regs_tb.sv ----
/*
 Self-checking bench for aerr_regs: APB accesses, event pulses, counts.
 Assumes the root model counts report pulses; no other stimulus source.
*/
`timescale 1ns/1ps
`default_nettype none
module aerr_regs_tb
	import aerr_pkg::*;
;
	logic           mclk;
	logic           reset_n;
	logic           clkEn;
	logic           warmReset;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [11:0]    paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	aerr_corr_evt_t corrEvt;
	aerr_unc_evt_t  uncEvt;
	aerr_report_t   report;
	logic           crcGenOn;
	logic           crcCheckOn;
	logic [31:0]    rd;
	logic           err;
	int             failCount;
	int             testsRun;
	int             fatCnt;
	int             nfCnt;
	int             corCnt;
	int             pos [6] = '{0, 6, 7, 8, 12, 13};

	aerr_regs uut (
		.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .warmReset(warmReset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.corrEvt(corrEvt), .uncEvt(uncEvt), .report(report),
		.crcGenOn(crcGenOn), .crcCheckOn(crcCheckOn)
	);
	aerr_root_model rc (
		.mclk(mclk), .reset_n(reset_n), .report(report),
		.fatalCnt(fatCnt), .nonFatalCnt(nfCnt), .corrCnt(corCnt)
	);

	// Core clock, 25 ns period
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		checkWord(rd, exp);
	endtask

	// One-cycle event pulse; the model's count settles one edge after the report
	task automatic fire(input aerr_corr_evt_t c, input aerr_unc_evt_t u);
		@(posedge mclk);
		corrEvt <= c;
		uncEvt <= u;
		@(posedge mclk);
		corrEvt <= '0;
		uncEvt <= '0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		{psel, penable, pwrite, warmReset, reset_n} = '0;
		clkEn = 1'b1;
		paddr = '0;
		pwdata = '0;
		corrEvt = '0;
		uncEvt = '0;
		failCount = 0;
		testsRun = 0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rdChk(AERR_OFF_CORR_STAT, 32'h0);
		rdChk(AERR_OFF_CORR_MASK, 32'h2000);
		rdChk(AERR_OFF_ERR_CTL, 32'ha0);
		rdChk(AERR_OFF_HDR_FIRST, 32'h0);
		rdChk(AERR_OFF_HDR_SECOND, 32'h0);
		rdChk(AERR_OFF_UNC_SEV, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			fire(aerr_corr_evt_t'(6'h1 << i), '0);
			rdChk(AERR_OFF_CORR_STAT, 32'h1 << pos[i]);
			apb(1'b1, AERR_OFF_CORR_STAT, 32'hffffffff);
			rdChk(AERR_OFF_CORR_STAT, 32'h0);
		end
		checkWord(32'(corCnt), 32'h5);
		apb(1'b1, AERR_OFF_CORR_MASK, 32'hffffffff);
		rdChk(AERR_OFF_CORR_MASK, 32'h31c1);
		fire(6'h3f, '0);
		checkWord(32'(corCnt), 32'h5);
		rdChk(AERR_OFF_CORR_STAT, 32'h31c1);
		$display("test correctable done");
		apb(1'b1, AERR_OFF_UNC_SEV, 32'hffffffff);
		rdChk(AERR_OFF_UNC_SEV, 32'h180000);
		apb(1'b1, AERR_OFF_UNC_SEV, 32'h80000);
		fire('0, {2'b01, 32'h11112222, 32'h33334444});
		checkWord(32'(fatCnt), 32'h1);
		fire('0, {2'b10, 32'h55556666, 32'h77778888});
		checkWord(32'(nfCnt), 32'h1);
		rdChk(AERR_OFF_ERR_CTL, 32'hb3);
		rdChk(AERR_OFF_HDR_FIRST, 32'h11112222);
		rdChk(AERR_OFF_HDR_SECOND, 32'h33334444);
		apb(1'b1, AERR_OFF_UNC_MASK, 32'h100000);
		apb(1'b1, AERR_OFF_UNC_STATUS, 32'h180000);
		fire('0, {2'b10, 32'h9, 32'ha});
		checkWord(32'(nfCnt), 32'h1);
		rdChk(AERR_OFF_UNC_STATUS, 32'h0);
		rdChk(AERR_OFF_HDR_FIRST, 32'h11112222);
		fire('0, {2'b01, 32'hbbbbcccc, 32'hddddeeee});
		checkWord(32'(fatCnt), 32'h2);
		rdChk(AERR_OFF_HDR_FIRST, 32'hbbbbcccc);
		$display("test uncorrectable done");
		apb(1'b1, AERR_OFF_ERR_CTL, 32'hffffffff);
		rdChk(AERR_OFF_ERR_CTL, 32'h1f3);
		checkWord({30'h0, crcGenOn, crcCheckOn}, 32'h3);
		apb(1'b1, AERR_OFF_CAP_LOCK, 32'h0);
		apb(1'b1, AERR_OFF_ERR_CTL, 32'h140);
		rdChk(AERR_OFF_ERR_CTL, 32'h153);
		checkWord({30'h0, crcGenOn, crcCheckOn}, 32'h0);
		$display("test control done");
		@(posedge mclk);
		warmReset <= 1'b1;
		@(posedge mclk);
		warmReset <= 1'b0;
		rdChk(AERR_OFF_ERR_CTL, 32'h1f3);
		rdChk(AERR_OFF_HDR_FIRST, 32'h0);
		rdChk(AERR_OFF_HDR_SECOND, 32'hddddeeee);
		rdChk(AERR_OFF_CORR_STAT, 32'h31c1);
		rdChk(AERR_OFF_CORR_MASK, 32'h31c1);
		apb(1'b0, 12'h111, 32'h0);
		checkWord({err, rd[30:0]}, 32'h80000000);
		$display("test warm reset done");
		wrapUp();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#1000000;
		failCount++;
		wrapUp();
	end
endmodule
`default_nettype wire
